// ==== include/pwd_pkg.sv ====
// constants and types shared by the program word decoder
// assumes one machine clock and a synchronous active-high general clear
`default_nettype none
package pwd_pkg;
   localparam int WORD_W     = 48;
   localparam int INSTR_W    = 24;
   localparam int OPC_W      = 6;
   localparam int DES_W      = 3;
   localparam int FUNC_W     = 9;
   localparam int ADDR_W     = 15;
   localparam int UPPER_LSB  = 24;
   localparam int LOWER_LSB  = 0;
   localparam int OPC_LSB    = 18;
   localparam int DES_LSB    = 15;
   localparam int CHAR_W     = 6;
   localparam int BANK_LOCS  = 16384;
   localparam logic [5:0] OPC_EXT_FUNC = 6'h3c;   // octal 74
   localparam logic [5:0] OPC_BAD_LOW  = 6'h00;   // octal 00
   localparam logic [5:0] OPC_BAD_HIGH = 6'h3f;   // octal 77
   localparam logic [5:0] OPC_JMP_A    = 6'h12;   // octal 22
   localparam logic [5:0] OPC_JMP_Q    = 6'h13;   // octal 23
   localparam logic [5:0] OPC_JMP_SEL  = 6'h3d;   // octal 75
   localparam logic [5:0] OPC_STOP_SEL = 6'h3e;   // octal 76
   localparam logic [5:0] OPC_RPL_LO   = 6'h38;   // octal 70
   localparam logic [5:0] OPC_RPL_HI   = 6'h3b;   // octal 73
   localparam logic [2:0] DES_SELECT   = 3'h0;
   localparam logic [2:0] DES_SENSE    = 3'h7;
   localparam int RET_BIT    = 2;                 // designator bit marking a return jump
   localparam int EXIT_LEAD  = 1;                 // cycles before the end that exit fires
   typedef enum logic [1:0] {PWD_IDLE, PWD_EXEC, PWD_WAIT} pwd_state_t;
   typedef enum logic [1:0] {PWD_ALU_PADD, PWD_ALU_MASK, PWD_ALU_EXT, PWD_ALU_PASS} pwd_alu_t;
endpackage
`default_nettype wire

// ==== hw/pwd_field_split.sv ====
// splits one 24-bit instruction into its fields and classes
// assumes the instruction is already selected from the word
`default_nettype none
module pwd_field_split (
   input  wire logic [23:0] instr,
   output logic      [5:0]  opcode,
   output logic      [2:0]  designator,
   output logic      [8:0]  func_code,
   output logic      [14:0] exec_addr,
   output logic      [7:0]  sub_form,
   output logic             is_jump,
   output logic             is_replace,
   output logic             is_illegal
);
   // slicing of the packed instruction, plus the subform and class decodes
   always_comb begin
      opcode     = instr[pwd_pkg::OPC_LSB +: pwd_pkg::OPC_W];
      designator = instr[pwd_pkg::DES_LSB +: pwd_pkg::DES_W];
      func_code  = instr[pwd_pkg::DES_LSB +: pwd_pkg::FUNC_W];
      exec_addr  = instr[0 +: pwd_pkg::ADDR_W];
      sub_form   = 8'h01 << designator;
      is_jump    = (opcode == pwd_pkg::OPC_JMP_A) || (opcode == pwd_pkg::OPC_JMP_Q)
                || (opcode == pwd_pkg::OPC_JMP_SEL) || (opcode == pwd_pkg::OPC_STOP_SEL);
      is_replace = (opcode >= pwd_pkg::OPC_RPL_LO) && (opcode <= pwd_pkg::OPC_RPL_HI);
      is_illegal = (opcode == pwd_pkg::OPC_BAD_LOW) || (opcode == pwd_pkg::OPC_BAD_HIGH);
   end
endmodule // pwd_field_split
`default_nettype wire

// ==== hw/pwd_program_word_decoder.sv ====
// program word decoder: sequences the two halves of a 48-bit word,
// exposes decoded fields, arithmetic helpers and a ready/resume channel
// assumes the control sequencer reports completion and skip conditions
`default_nettype none
module pwd_program_word_decoder #(
   parameter int WORD_W = pwd_pkg::WORD_W,
   parameter int CHAR_W = pwd_pkg::CHAR_W
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              general_clear,
   // new program word from storage
   input  wire logic              word_valid,
   input  wire logic [47:0]       word_in,
   input  wire logic [14:0]       word_addr,
   // control sequencer handshakes
   input  wire logic              seq_near_done,
   input  wire logic              seq_done,
   input  wire logic              skip_cond,
   input  wire logic              jump_taken,
   input  wire logic              fault_in,
   input  wire logic              fault_halt_en,
   output logic                   word_request,
   output logic                   seq_start,
   output logic                   exit_pulse,
   output logic                   half_sel,
   output logic                   busy,
   // decoded fields of the current instruction
   output logic      [5:0]        opcode,
   output logic      [2:0]        designator,
   output logic      [8:0]        func_code,
   output logic      [14:0]       exec_addr,
   output logic      [14:0]       upper_addr,
   output logic      [14:0]       lower_addr,
   output logic      [7:0]        sub_form,
   output logic                   ext_select,
   output logic                   ext_sense,
   output logic                   odd_bank_sel,
   output logic      [13:0]       bank_index,
   output logic      [14:0]       write_back_addr,
   output logic                   write_back_en,
   output logic      [14:0]       return_addr,
   output logic                   return_valid,
   output logic                   fault_flag,
   output logic                   halted,
   output logic                   int_request,
   // arithmetic helper
   input  wire logic [1:0]        alu_op,
   input  wire logic [47:0]       alu_a,
   input  wire logic [47:0]       alu_b,
   input  wire logic [4:0]        ext_width,
   output logic      [47:0]       alu_result,
   output logic                   alu_negative,
   // outgoing channel: this block sends
   output logic      [47:0]       chan_data,
   output logic                   chan_ready,
   input  wire logic              chan_resume,
   input  wire logic              chan_send,
   input  wire logic [47:0]       chan_send_data,
   input  wire logic              chan_char_mode,
   output logic                   chan_send_busy
);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      pwd_pkg::pwd_state_t state;
      logic [47:0]         word;
      logic [14:0]         addr;
      logic                half;
      logic                skip_lower;
      logic                start;
      logic                exit_p;
      logic                fault;
      logic                halt;
      logic                irq;
      logic [14:0]         ret_addr;
      logic                ret_valid;
      logic [47:0]         chan_word;
      logic                chan_rdy;
      logic                chan_busy;
   } pwd_regs_t;

   pwd_regs_t r;
   pwd_regs_t next_r;

   logic [23:0] cur_instr;
   logic        cur_jump;
   logic        cur_replace;
   logic        cur_illegal;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // sign of a one's complement value is its top stage
   function automatic logic sign_of(input logic [47:0] v, input logic [4:0] w);
      logic [5:0] top;
      top = {1'b0, w};
      sign_of = v[top];
   endfunction

   // copy the sign bit of a w+1 bit field into every higher stage
   function automatic logic [47:0] sign_extend(input logic [47:0] v, input logic [4:0] w);
      logic [47:0] res;
      logic        s;
      res = v;
      s = sign_of(v, w);
      for (int i = 0; i < 48; i++) begin
         if (i > int'(w)) begin
            res[i] = s;
         end
      end
      sign_extend = res;
   endfunction

   // one instruction of the word: upper half when sel is low, lower half when high
   function automatic logic [23:0] half_of(input logic [47:0] w, input logic sel);
      logic [23:0] res;
      if (sel) begin
         res = w[pwd_pkg::LOWER_LSB +: pwd_pkg::INSTR_W];
      end else begin
         res = w[pwd_pkg::UPPER_LSB +: pwd_pkg::INSTR_W];
      end
      half_of = res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // field split of the selected half
   always_comb begin
      cur_instr = half_of(r.word, r.half);
   end

   pwd_field_split u_split (
      .instr      (cur_instr),
      .opcode     (opcode),
      .designator (designator),
      .func_code  (func_code),
      .exec_addr  (exec_addr),
      .sub_form   (sub_form),
      .is_jump    (cur_jump),
      .is_replace (cur_replace),
      .is_illegal (cur_illegal)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing of the two halves, exit overlap, faults and channel
   always_comb begin
      next_r        = r;
      next_r.start  = 1'b0;
      next_r.exit_p = 1'b0;
      case (r.state)
         pwd_pkg::PWD_IDLE: begin
            // a halted block takes no word until a clear
            if (word_valid && !r.halt) begin
               next_r.word       = word_in;
               next_r.addr       = word_addr;
               next_r.half       = 1'b0;
               next_r.skip_lower = 1'b0;
               next_r.start      = 1'b1;
               next_r.state      = pwd_pkg::PWD_EXEC;
            end
         end
         pwd_pkg::PWD_EXEC: begin
            // exit fires the cycle after near-done so the next sequence overlaps
            if (seq_near_done && !r.exit_p) begin
               next_r.exit_p = 1'b1;
            end
            // the skip is remembered so an early report from the sequencer still counts
            if (!r.half && skip_cond) begin
               next_r.skip_lower = 1'b1;
            end
            if (seq_done) begin
               if (!r.half && !jump_taken && !(r.skip_lower || skip_cond)) begin
                  next_r.half  = 1'b1;
                  next_r.start = 1'b1;
               end else begin
                  next_r.state = pwd_pkg::PWD_WAIT;
               end
               if (cur_jump && jump_taken) begin
                  // only the return forms leave a resume point behind
                  if (designator[pwd_pkg::RET_BIT]) begin
                     next_r.ret_addr  = r.addr + 15'h0001;
                     next_r.ret_valid = 1'b1;
                  end else begin
                     next_r.ret_valid = 1'b0;
                  end
               end
            end
         end
         pwd_pkg::PWD_WAIT: begin
            // one spare cycle lets the last sequence settle before a new word
            next_r.state = pwd_pkg::PWD_IDLE;
         end
         default: begin
            next_r.state = pwd_pkg::PWD_IDLE;
         end
      endcase

      // faults: sticky indicator, optional halt, interrupt request
      if (fault_in || (r.state == pwd_pkg::PWD_EXEC && cur_illegal)) begin
         next_r.fault = 1'b1;
         next_r.irq   = 1'b1;
         if (fault_halt_en) begin
            next_r.halt  = 1'b1;
            next_r.state = pwd_pkg::PWD_IDLE;
         end
      end

      // send side: ready once placed, next item only after resume
      if (r.chan_busy) begin
         if (chan_resume) begin
            next_r.chan_rdy  = 1'b0;
            next_r.chan_busy = 1'b0;
         end
      end else if (chan_send) begin
         // a character rides in the low stages with zeros above it
         next_r.chan_word = chan_char_mode ?
                            {{(WORD_W-CHAR_W){1'b0}}, chan_send_data[CHAR_W-1:0]}
                          : chan_send_data;
         next_r.chan_rdy  = 1'b1;
         next_r.chan_busy = 1'b1;
      end

      // general clear overrides every other update, a fault in the same cycle too
      if (general_clear) begin
         next_r = '0;
      end
   end

   // single register stage for the whole state
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // arithmetic helper, combinational
   always_comb begin
      case (pwd_pkg::pwd_alu_t'(alu_op))
         pwd_pkg::PWD_ALU_PADD: alu_result = alu_a ^ alu_b;
         pwd_pkg::PWD_ALU_MASK: alu_result = alu_a & alu_b;
         pwd_pkg::PWD_ALU_EXT:  alu_result = sign_extend(alu_a, ext_width);
         default:               alu_result = alu_a;
      endcase
      // the top stage of the full word is the sign; a narrower field is
      // only signed once it has been extended
      alu_negative = alu_result[WORD_W-1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   always_comb begin
      word_request    = (r.state == pwd_pkg::PWD_IDLE) && !r.halt;
      seq_start       = r.start;
      exit_pulse      = r.exit_p;
      half_sel        = r.half;
      busy            = (r.state != pwd_pkg::PWD_IDLE);

      // both address halves come straight from the held word
      upper_addr      = r.word[pwd_pkg::UPPER_LSB +: pwd_pkg::ADDR_W];
      lower_addr      = r.word[pwd_pkg::LOWER_LSB +: pwd_pkg::ADDR_W];

      // subforms of the external function code
      ext_select      = (opcode == pwd_pkg::OPC_EXT_FUNC)
                     && (designator == pwd_pkg::DES_SELECT);
      ext_sense       = (opcode == pwd_pkg::OPC_EXT_FUNC)
                     && (designator == pwd_pkg::DES_SENSE);

      // the low address bit picks the storage unit, the rest indexes it
      odd_bank_sel    = exec_addr[0];
      bank_index      = exec_addr[14:1];

      // replace forms write back where their operand came from
      write_back_addr = exec_addr;
      write_back_en   = cur_replace && (r.state == pwd_pkg::PWD_EXEC);

      // sticky levels straight from the registered state
      return_addr     = r.ret_addr;
      return_valid    = r.ret_valid;
      fault_flag      = r.fault;
      halted          = r.halt;
      int_request     = r.irq;

      // channel outputs stand until the receiver resumes
      chan_data       = r.chan_word;
      chan_ready      = r.chan_rdy;
      chan_send_busy  = r.chan_busy;
   end

endmodule // pwd_program_word_decoder
`default_nettype wire

// ==== test/pwd_program_word_decoder_assertions.sv ====
// checker for the program word decoder, watching only its top ports
// assumes one clock and a synchronous active-high reset
`default_nettype none
module pwd_checker (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        general_clear,
   input wire logic        word_valid,
   input wire logic        word_request,
   input wire logic        seq_start,
   input wire logic        half_sel,
   input wire logic        seq_near_done,
   input wire logic        exit_pulse,
   input wire logic        busy,
   input wire logic        fault_in,
   input wire logic        fault_flag,
   input wire logic        int_request,
   input wire logic [5:0]  opcode,
   input wire logic [2:0]  designator,
   input wire logic [8:0]  func_code,
   input wire logic [14:0] exec_addr,
   input wire logic        odd_bank_sel,
   input wire logic        chan_ready,
   input wire logic        chan_resume
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // a word is taken only when offered and requested, clear wins over it
   sequence s_taken;
      word_valid && word_request && !general_clear;
   endsequence
   sequence s_upper_start;
      seq_start && !half_sel ##1 !seq_start;
   endsequence
   a_func_join:   assert property (func_code == {opcode, designator})
      else $error("function code is not opcode then designator");
   a_bank_route:  assert property (odd_bank_sel == exec_addr[0])
      else $error("odd address not routed to odd bank");
   a_upper_first: assert property (s_taken |=> s_upper_start)
      else $error("upper half not started first");
   a_exit_follow: assert property (exit_pulse |-> $past(seq_near_done))
      else $error("exit without near completion");
   a_clear_zero:  assert property (general_clear |=> !busy && !half_sel && !fault_flag)
      else $error("general clear left state set");
   a_ready_hold:  assert property (chan_ready && !chan_resume && !general_clear |=> chan_ready)
      else $error("ready dropped before resume");
   a_resume_drop: assert property (chan_ready && chan_resume |=> !chan_ready)
      else $error("ready stayed after resume");
   a_fault_int:   assert property (fault_in && busy && !general_clear |=>
      fault_flag && int_request)
      else $error("fault did not raise flag and request");
endmodule // pwd_checker
bind pwd_program_word_decoder pwd_checker pwd_checker_inst (.sys_clk, .reset, .general_clear,
   .word_valid, .word_request, .seq_start, .half_sel, .seq_near_done, .exit_pulse, .busy,
   .fault_in, .fault_flag, .int_request, .opcode, .designator, .func_code, .exec_addr,
   .odd_bank_sel, .chan_ready, .chan_resume);
`default_nettype wire

// ==== test/pwd_seq_partner.sv ====
// model of the control sequencer and of the channel's receiving end
// assumes the same clock and reset as the decoder
`default_nettype none
module pwd_seq_partner #(
   parameter int DLY  = 5,
   parameter int RDLY = 3
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic seq_start,
   input  wire logic chan_ready,
   output logic      seq_near_done,
   output logic      seq_done,
   output logic      chan_resume
);
   timeunit 1ns;
   timeprecision 1ps;
   int sc;
   int rc;
   // near-done comes a cycle before done so the next sequence can overlap
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sc            <= 0;
         rc            <= 0;
         seq_near_done <= 1'b0;
         seq_done      <= 1'b0;
         chan_resume   <= 1'b0;
      end else begin
         sc            <= seq_start ? DLY : (sc > 0 ? sc - 1 : 0);
         seq_near_done <= (sc == 3);
         seq_done      <= (sc == 2);
         // resume is asked only after ready, and once per item
         if (chan_ready && rc == 0 && !chan_resume) rc <= RDLY;
         else if (rc > 0) rc <= rc - 1;
         chan_resume   <= (rc == 1);
      end
   end
endmodule // pwd_seq_partner
`default_nettype wire

// ==== test/pwd_program_word_decoder_tb_top.sv ====
// self-checking bench: alu table, word sequencing, jumps, channel, fault
// assumes the partner model drives the sequencer handshakes
`default_nettype none
module pwd_program_word_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] op; logic [47:0] a, b; logic [4:0] w; logic [47:0] e;} pwd_row_t;
   logic sys_clk = 0, reset = 1, general_clear = 0, word_valid = 0, skip_cond = 0;
   logic jump_taken = 0, fault_in = 0, fault_halt_en = 0, chan_send = 0, chan_char_mode = 0;
   logic [47:0] word_in = '0, alu_a = '0, alu_b = '0, chan_send_data = '0, alu_result, chan_data;
   logic [14:0] word_addr = '0, exec_addr, upper_addr, lower_addr, write_back_addr, return_addr;
   logic [1:0] alu_op = '0;
   logic [4:0] ext_width = '0;
   logic seq_near_done, seq_done, word_request, seq_start, exit_pulse, half_sel, busy, ext_select;
   logic ext_sense, odd_bank_sel, write_back_en, return_valid, fault_flag, halted, int_request;
   logic alu_negative, chan_ready, chan_resume, chan_send_busy;
   logic [5:0] opcode;
   logic [2:0] designator;
   logic [8:0] func_code;
   logic [7:0] sub_form;
   logic [13:0] bank_index;
   int miscompares = 0, cmp_count = 0, starts = 0, exits = 0, s0, e0;
   pwd_row_t rows[6] = '{
      '{2'h0, 48'h0f0f_0000_ffff, 48'h00ff_00ff_0f0f, 5'h00, 48'h0ff0_00ff_f0f0},
      '{2'h1, 48'h1234_5678_9abc, 48'hffff_0000_0ff0, 5'h00, 48'h1234_0000_0ab0},
      '{2'h2, 48'h0000_0000_4000, 48'h0000_0000_0000, 5'h0e, 48'hffff_ffff_c000},
      '{2'h2, 48'hffff_0000_3fff, 48'h0000_0000_0000, 5'h0e, 48'h0000_0000_3fff},
      '{2'h3, 48'h8000_0000_0001, 48'h0000_0000_0000, 5'h00, 48'h8000_0000_0001},
      '{2'h3, 48'h7fff_8000_0000, 48'h0000_0000_0000, 5'h00, 48'h7fff_8000_0000}};
   pwd_program_word_decoder pwd_program_word_decoder_inst (.sys_clk, .reset, .general_clear,
      .word_valid, .word_in, .word_addr, .seq_near_done, .seq_done, .skip_cond, .jump_taken,
      .fault_in, .fault_halt_en, .word_request, .seq_start, .exit_pulse, .half_sel, .busy,
      .opcode, .designator, .func_code, .exec_addr, .upper_addr, .lower_addr, .sub_form,
      .ext_select, .ext_sense, .odd_bank_sel, .bank_index, .write_back_addr, .write_back_en,
      .return_addr, .return_valid, .fault_flag, .halted, .int_request, .alu_op, .alu_a, .alu_b,
      .ext_width, .alu_result, .alu_negative, .chan_data, .chan_ready, .chan_resume, .chan_send,
      .chan_send_data, .chan_char_mode, .chan_send_busy);
   pwd_seq_partner pwd_seq_partner_inst (.sys_clk, .reset, .seq_start, .chan_ready,
      .seq_near_done, .seq_done, .chan_resume);
   ////////////////////////////////////////////////////////////////////////////////
   // clock, and counters of sequence starts and exits seen at each edge
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (seq_start === 1'b1) starts++;
      if (exit_pulse === 1'b1) exits++;
   end
   task chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) begin @(posedge sys_clk); #1; end
   endtask
   // bounded wait so a stuck handshake shows as a mismatch, not a hang
   task automatic wait_lvl(ref logic s, input logic v);
      int k = 0;
      while (s !== v && k < 100) begin tick(1); k++; end
      chk(s, v);
   endtask
   function automatic logic [23:0] ins(logic [5:0] op, logic [2:0] d, logic [14:0] a);
      return {op, d, a};
   endfunction
   task send_word(input logic [23:0] up, input logic [23:0] lo, input logic [14:0] adr);
      word_in = {up, lo}; word_addr = adr; word_valid = 1; s0 = starts; e0 = exits;
      tick(1);
      word_valid = 0;
   endtask
   task test_done;
      $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      miscompares++;
      $display("mismatch t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 reset = 0;
      chk(word_request, 1); chk(busy, 0);
      foreach (rows[i]) begin
         alu_op = rows[i].op; alu_a = rows[i].a; alu_b = rows[i].b; ext_width = rows[i].w;
         tick(1);
         chk(alu_result, rows[i].e);
         chk(alu_negative, rows[i].e[47]);
      end
      // select code upper, replace lower: fields steer with the half flag
      send_word(ins(6'h3c, 3'h0, 15'h1235), ins(6'h38, 3'h2, 15'h0007), 15'h0040);
      chk(func_code, 9'h1e0); chk(opcode, 6'h3c);
      chk(exec_addr, 15'h1235); chk(upper_addr, 15'h1235);
      chk(lower_addr, 15'h0007); chk(half_sel, 0);
      chk(ext_select, 1); chk(sub_form, 8'h01);
      chk(odd_bank_sel, 1); chk(bank_index, 14'h091a);
      wait_lvl(half_sel, 1);
      chk(designator, 3'h2); chk(exec_addr, 15'h0007); chk(sub_form, 8'h04);
      chk(write_back_en, 1); chk(write_back_addr, 15'h0007);
      wait_lvl(busy, 0);
      chk(starts - s0, 2); chk(exits - e0, 2);
      // sense code with skip condition met: lower half never starts
      skip_cond = 1;
      send_word(ins(6'h3c, 3'h7, 15'h0002), ins(6'h01, 3'h0, 15'h0003), 15'h0041);
      chk(ext_sense, 1); chk(sub_form, 8'h80);
      wait_lvl(busy, 0);
      skip_cond = 0;
      chk(starts - s0, 1);
      // return jump saves address plus one, a normal jump saves nothing
      jump_taken = 1;
      send_word(ins(6'h12, 3'h4, 15'h0100), ins(6'h01, 3'h0, 15'h0003), 15'h0abc);
      wait_lvl(busy, 0);
      chk(return_valid, 1); chk(return_addr, 15'h0abd); chk(starts - s0, 1);
      send_word(ins(6'h13, 3'h0, 15'h0100), ins(6'h01, 3'h0, 15'h0003), 15'h0abe);
      wait_lvl(busy, 0);
      jump_taken = 0;
      chk(return_valid, 0);
      // channel word: ready with data, held until the slow resume
      chan_send_data = 48'ha5a5_0000_5a5a; chan_send = 1;
      tick(1);
      chan_send = 0;
      chk(chan_ready, 1); chk(chan_data, 48'ha5a5_0000_5a5a);
      chk(chan_send_busy, 1);
      wait_lvl(chan_ready, 0);
      chk(chan_send_busy, 0);
      // character mode keeps the low six bits only; a send while busy is refused
      chan_send_data = 48'hffff_ffff_ffe7; chan_char_mode = 1; chan_send = 1;
      tick(1);
      chan_send_data = 48'h0000_0000_0011;
      chk(chan_data, 48'h0000_0000_0027); chk(chan_send_busy, 1);
      tick(1);
      chan_send = 0;
      chk(chan_data, 48'h0000_0000_0027); chk(chan_ready, 1);
      wait_lvl(chan_ready, 0);
      chan_char_mode = 0;
      // fault in mid-execution with halting enabled, then a general clear
      fault_halt_en = 1;
      send_word(ins(6'h10, 3'h0, 15'h0004), ins(6'h01, 3'h0, 15'h0005), 15'h0042);
      fault_in = 1;
      tick(1);
      fault_in = 0;
      chk(fault_flag, 1); chk(int_request, 1);
      tick(2);
      chk(halted, 1); chk(word_request, 0);
      general_clear = 1;
      tick(1);
      general_clear = 0; fault_halt_en = 0;
      chk(fault_flag, 0); chk(halted, 0); chk(word_request, 1);
      // let the sequence cut by the halt run out in the partner first
      tick(4);
      // an unused operation code faults without halting when halting is off
      send_word(ins(6'h3f, 3'h0, 15'h0006), ins(6'h01, 3'h0, 15'h0007), 15'h0043);
      tick(1);
      chk(fault_flag, 1); chk(int_request, 1); chk(halted, 0);
      wait_lvl(busy, 0);
      chk(starts - s0, 2); chk(word_request, 1);
      test_done();
   end
endmodule // pwd_program_word_decoder_tb_top
`default_nettype wire
